// File: verilog/alos_top.sv
// List offset registers, address forming and sample sequencing control
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "alos_regs.svh"
module alos_top
	import alos_pkg::*;
#(
	parameter int CH_W = 4
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Conversion engine side
	input wire logic conv_start,
	input wire logic [CH_W-1:0] conv_channel,
	input wire logic cmd_advance,
	input wire logic res_advance,
	input wire logic [5:0] cmd_idx_load,
	input wire logic cmd_idx_wr,
	// Memory addresses
	output logic [23:0] cmd_addr,
	output logic [19:0] res_addr,
	// Analog switches and conversion done
	output logic pump_on,
	output logic buf_connect,
	output logic direct_connect,
	output logic [(1<<CH_W)-1:0] mux_sel,
	output logic conv_done
);
	typedef struct packed {
		logic en;
		logic sacc;
		logic lsel;
		logic [21:0] cbp;
		logic [17:0] rbp;
		logic [5:0] cidx;
		logic [5:0] ridx;
		logic [6:0] off1;
		logic [4:0] smp;
		logic [7:0] div;
		logic [31:0] rdata;
		logic [23:0] caddr;
		logic [19:0] raddr;
		logic pump;
		logic bufc;
		logic dirc;
		logic [(1<<CH_W)-1:0] mux;
		logic [CH_W-1:0] chan;
		logic busy;
		logic done;
	} alos_top_st_t;
	alos_top_st_t s_q, s_d;

	alos_seq_if sq ();
	logic unlocked;
	logic [6:0] act_off;
	logic [23:0] off_c;
	logic [19:0] off_r;

	alos_sample_seq u_seq (
		.clk(clk),
		.rst_b(rst_b),
		.sq(sq.seq)
	);

	assign unlocked = !s_q.en || s_q.sacc;
	assign act_off = s_q.lsel ? s_q.off1 : `ALOS_SET0_VALUE;
	// Command units are 4 bytes, result units 2 bytes
	assign off_c = {15'h0000, act_off + {1'b0, s_q.cidx}, 2'b00};
	assign off_r = {12'h000, act_off + {1'b0, s_q.ridx}, 1'b0};

	assign sq.tick = (s_q.div == 8'h00);
	assign sq.start = s_q.busy && conv_start;
	assign sq.smp_cycles = s_q.smp;

	always_comb
	begin
		s_d = s_q;
		s_d.div = (s_q.div == 8'h00) ? `ALOS_CLK_DIV : s_q.div - 8'h01;
		s_d.rdata = 32'h0000_0000;
		s_d.done = sq.done;
		if (reg_wr)
		begin
			case (reg_addr)
				`ALOS_OFF_CTRL:
				begin
					s_d.en = reg_wdata[`ALOS_CTRL_EN];
					s_d.sacc = reg_wdata[`ALOS_CTRL_SACC];
					s_d.lsel = reg_wdata[`ALOS_CTRL_LSEL];
				end
				`ALOS_OFF_CMD_BASE:
					if (unlocked)
						s_d.cbp = reg_wdata[23:2];
				`ALOS_OFF_RES_BASE:
					if (unlocked)
						s_d.rbp = reg_wdata[19:2];
				`ALOS_OFF_SET1:
					if (unlocked)
						s_d.off1 = reg_wdata[6:0];
				`ALOS_OFF_CONV:
				begin
					if (reg_wdata[4:0] >= `ALOS_SMP_MIN && reg_wdata[4:0] <= `ALOS_SMP_MAX)
						s_d.smp = reg_wdata[4:0];
				end
				default:
				begin
				end
			endcase
		end
		// Index owned by the converter while enabled
		if (s_q.en && cmd_idx_wr)
			s_d.cidx = cmd_idx_load;
		else if (s_q.en && cmd_advance)
			s_d.cidx = s_q.cidx + 6'h01;
		else if (!s_q.en)
			s_d.cidx = 6'h00;
		if (s_q.en && res_advance)
			s_d.ridx = s_q.ridx + 6'h01;
		else if (!s_q.en)
			s_d.ridx = 6'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`ALOS_OFF_CTRL:
					s_d.rdata = {29'h0, s_q.lsel, s_q.sacc, s_q.en};
				`ALOS_OFF_CMD_BASE:
					s_d.rdata = {8'h00, s_q.cbp, 2'b00};
				`ALOS_OFF_RES_BASE:
					s_d.rdata = {12'h000, s_q.rbp, 2'b00};
				`ALOS_OFF_CMD_IDX:
					s_d.rdata = {26'h0, s_q.cidx};
				`ALOS_OFF_RES_IDX:
					s_d.rdata = {26'h0, s_q.ridx};
				`ALOS_OFF_SET0:
					s_d.rdata = {25'h0, `ALOS_SET0_VALUE};
				`ALOS_OFF_SET1:
					s_d.rdata = {25'h0, s_q.off1};
				`ALOS_OFF_CONV:
					s_d.rdata = {27'h0, s_q.smp};
				`ALOS_OFF_STATUS:
					s_d.rdata = {28'h0, 1'b0, sq.phase};
				`ALOS_OFF_CMD_ADDR:
					s_d.rdata = {8'h00, s_q.caddr};
				`ALOS_OFF_RES_ADDR:
					s_d.rdata = {12'h000, s_q.raddr};
				default:
					s_d.rdata = 32'h0000_0000;
			endcase
		end
		s_d.caddr = {s_q.cbp, 2'b00} + off_c;
		s_d.raddr = {s_q.rbp, 2'b00} + off_r;
		// Channel latched at start, held through the conversion
		if (!s_q.en)
			s_d.busy = 1'b0;
		else if (!s_q.busy)
			s_d.busy = 1'b1;
		if (sq.tick && sq.phase == ALOS_IDLE && sq.start)
			s_d.chan = conv_channel;
		s_d.pump = (sq.phase == ALOS_PUMP);
		s_d.bufc = (sq.phase == ALOS_BUF);
		s_d.dirc = (sq.phase == ALOS_DIRECT);
		s_d.mux = '0;
		if (sq.phase == ALOS_BUF || sq.phase == ALOS_DIRECT)
			s_d.mux[s_q.chan] = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q <= '0;
			s_q.off1 <= `ALOS_SET1_RESET;
			s_q.smp <= `ALOS_SMP_MIN;
			s_q.div <= `ALOS_CLK_DIV;
		end
		else
			s_q <= s_d;
	end

	assign reg_rdata = s_q.rdata;
	assign cmd_addr = s_q.caddr;
	assign res_addr = s_q.raddr;
	assign pump_on = s_q.pump;
	assign buf_connect = s_q.bufc;
	assign direct_connect = s_q.dirc;
	assign mux_sel = s_q.mux;
	assign conv_done = s_q.done;

	chk_set1_locked: assert property (@(posedge clk) disable iff (!rst_b)
		(reg_wr && reg_addr == `ALOS_OFF_SET1 && s_q.en && !s_q.sacc) |=> $stable(s_q.off1))
		else $error("set-1 offset changed while locked");
	chk_set1_write: assert property (@(posedge clk) disable iff (!rst_b)
		(reg_wr && reg_addr == `ALOS_OFF_SET1 && (!s_q.en || s_q.sacc))
		|=> s_q.off1 == $past(reg_wdata[6:0]))
		else $error("set-1 offset write lost");
	chk_set0_zero: assert property (@(posedge clk) disable iff (!rst_b)
		(reg_rd && reg_addr == `ALOS_OFF_SET0) |=> reg_rdata == 32'h0000_0000)
		else $error("set-0 offset not zero");
	chk_cmd_addr_sum: assert property (@(posedge clk) disable iff (!rst_b)
		$stable(s_q.cbp) && $stable(s_q.cidx) && $stable(s_q.lsel) && $stable(s_q.off1)
		|-> cmd_addr == {s_q.cbp, 2'b00} + {15'h0000, act_off + {1'b0, s_q.cidx}, 2'b00})
		else $error("command address wrong");
	chk_set0_addr: assert property (@(posedge clk) disable iff (!rst_b)
		(!s_q.lsel && $stable(s_q.rbp) && $stable(s_q.ridx) && $stable(s_q.lsel))
		|-> res_addr == {s_q.rbp, 2'b00} + {13'h0000, s_q.ridx, 1'b0})
		else $error("set-0 result address uses nonzero offset");
	chk_hold_open: assert property (@(posedge clk) disable iff (!rst_b)
		(sq.phase == ALOS_HOLD) |=> mux_sel == '0 && !buf_connect && !direct_connect)
		else $error("input connected during hold");
	chk_one_channel: assert property (@(posedge clk) disable iff (!rst_b)
		(buf_connect || direct_connect) |-> $onehot(mux_sel))
		else $error("not exactly one channel connected");
	chk_buf_two: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(buf_connect) |-> buf_connect [*4] ##1 !buf_connect)
		else $error("buffered sample not two converter cycles");
	chk_pump_two: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(pump_on) |-> pump_on [*4] ##1 buf_connect)
		else $error("pump not two cycles before sample");
	chk_cbp_locked: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.en && !s_q.sacc) |=> $stable(s_q.cbp) && $stable(s_q.rbp))
		else $error("base pointer changed while enabled");
endmodule

// File: include/alos_regs.svh
// Register offsets, fields, reset values and timing counts
// Function
// - Set-0 offset reads zero, never writable
// - Zero offset addresses first command/result lists
// - Offsets count samples: 32bit commands, 16bit results
// - Set-1 writes only when disabled or special access
// - Programmable 7-bit set-1 offset for second lists
// - Active offset used for fetch and store
// - First two sample cycles through buffer amplifier
// - Two-cycle pump phase before every sample
// - Input disconnected during whole hold phase
// - Exactly one channel connected per conversion
// - Address = base + active offset + index
// - Address registers locked when enabled unless special access, index owned when enabled
`ifndef ALOS_REGS_SVH
`define ALOS_REGS_SVH
`define ALOS_OFF_CTRL 8'h00
`define ALOS_OFF_CMD_BASE 8'h04
`define ALOS_OFF_RES_BASE 8'h08
`define ALOS_OFF_CMD_IDX 8'h0C
`define ALOS_OFF_RES_IDX 8'h10
`define ALOS_OFF_SET0 8'h14
`define ALOS_OFF_SET1 8'h18
`define ALOS_OFF_CONV 8'h1C
`define ALOS_OFF_STATUS 8'h20
`define ALOS_OFF_CMD_ADDR 8'h24
`define ALOS_OFF_RES_ADDR 8'h28
`define ALOS_CTRL_EN 0
`define ALOS_CTRL_SACC 1
`define ALOS_CTRL_LSEL 2
`define ALOS_SET0_VALUE 7'h00
`define ALOS_SET1_RESET 7'h00
`define ALOS_PUMP_CYCLES 5'h02
`define ALOS_BUF_CYCLES 5'h02
`define ALOS_SMP_MIN 5'h04
`define ALOS_SMP_MAX 5'h18
`define ALOS_CLK_DIV 8'h01
`endif

// File: include/alos_pkg.sv
// Types for the list offset and sample sequencer
package alos_pkg;
	typedef enum logic [2:0] {ALOS_IDLE, ALOS_PUMP, ALOS_BUF, ALOS_DIRECT, ALOS_HOLD} alos_phase_t;
endpackage

// File: include/alos_seq_if.sv
// Sequencer start, sample time and phase outputs
`timescale 1ns/10ps
interface alos_seq_if;
	import alos_pkg::*;
	logic start;
	logic tick;
	logic [4:0] smp_cycles;
	alos_phase_t phase;
	logic done;
	modport ctrl (output start, output tick, output smp_cycles, input phase, input done);
	modport seq (input start, input tick, input smp_cycles, output phase, output done);
endinterface

// File: verilog/alos_sample_seq.sv
// Conversion phase sequencer: pump, buffered, direct sample, hold
`timescale 1ns/10ps
`include "alos_regs.svh"
module alos_sample_seq
	import alos_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control side
	alos_seq_if.seq sq
);
	typedef struct packed {
		alos_phase_t phase;
		logic [4:0] cnt;
		logic [4:0] direct;
		logic done;
	} alos_seq_st_t;
	alos_seq_st_t s_q, s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (sq.tick)
		begin
			case (s_q.phase)
				ALOS_IDLE:
				begin
					if (sq.start)
					begin
						s_d.phase = ALOS_PUMP;
						s_d.cnt = `ALOS_PUMP_CYCLES - 5'h01;
						s_d.direct = sq.smp_cycles - `ALOS_BUF_CYCLES;
					end
				end
				ALOS_PUMP:
				begin
					if (s_q.cnt == 5'h00)
					begin
						s_d.phase = ALOS_BUF;
						s_d.cnt = `ALOS_BUF_CYCLES - 5'h01;
					end
					else
						s_d.cnt = s_q.cnt - 5'h01;
				end
				ALOS_BUF:
				begin
					if (s_q.cnt == 5'h00)
					begin
						s_d.phase = ALOS_DIRECT;
						s_d.cnt = s_q.direct - 5'h01;
					end
					else
						s_d.cnt = s_q.cnt - 5'h01;
				end
				ALOS_DIRECT:
				begin
					if (s_q.cnt == 5'h00)
						s_d.phase = ALOS_HOLD;
					else
						s_d.cnt = s_q.cnt - 5'h01;
				end
				ALOS_HOLD:
				begin
					s_d.phase = ALOS_IDLE;
					s_d.done = 1'b1;
				end
				default:
					s_d.phase = ALOS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign sq.phase = s_q.phase;
	assign sq.done = s_q.done;

	chk_pump_to_buf: assert property (@(posedge clk) disable iff (!rst_b)
		(sq.tick && s_q.phase == ALOS_PUMP && s_q.cnt == 5'h00) |=> s_q.phase == ALOS_BUF)
		else $error("pump did not lead to buffered sample");
endmodule

// File: verification/alos_engine_model.sv
// Conversion engine stand-in driving starts and index advances
`timescale 1ns/10ps
module alos_engine_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bench control
	input wire logic go,
	// Sequencer side
	input wire logic pump_on,
	input wire logic conv_done,
	output logic conv_start,
	output logic cmd_advance,
	output logic res_advance
);
	// Start held until pump seen, indices stepped after each done
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			conv_start <= 1'b0;
			cmd_advance <= 1'b0;
			res_advance <= 1'b0;
		end
		else
		begin
			conv_start <= (conv_start | go) & !pump_on;
			cmd_advance <= conv_done;
			res_advance <= conv_done;
		end
	end
endmodule

// File: verification/alos_top_tb.sv
// Self-checking bench for the list offset and sample sequencer
`timescale 1ns/10ps
`include "alos_regs.svh"
module alos_top_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, rv;
	logic go = 1'b0;
	logic conv_start, cmd_advance, res_advance, pump_on, buf_connect, direct_connect, conv_done;
	logic [3:0] conv_channel = 4'h9;
	logic [5:0] cmd_idx_load = 6'h00;
	logic cmd_idx_wr = 1'b0;
	logic [23:0] cmd_addr;
	logic [19:0] res_addr;
	logic [15:0] mux_sel;
	int mismatches = 0;
	int compares = 0;
	int cyc = 0;
	int n_pump = 0;
	int n_buf = 0;
	int n_dir = 0;
	int n_done = 0;
	int bad = 0;
	logic [7:0] ra [8] = '{`ALOS_OFF_SET1, `ALOS_OFF_SET1, `ALOS_OFF_SET0, `ALOS_OFF_CONV,
		`ALOS_OFF_CONV, `ALOS_OFF_CONV, 8'h30, `ALOS_OFF_CMD_BASE};
	logic [31:0] rw [8] = '{32'h7F, 32'hFF, 32'h55, 32'h19, 32'h5, 32'h3, 32'h1, 32'h100};
	logic [31:0] rx [8] = '{32'h7F, 32'h7F, 32'h0, 32'h4, 32'h5, 32'h5, 32'h0, 32'h100};
	always #5 clk = ~clk;
	alos_top alos_top_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
		.conv_channel(conv_channel), .cmd_advance(cmd_advance), .res_advance(res_advance),
		.cmd_idx_load(cmd_idx_load), .cmd_idx_wr(cmd_idx_wr), .cmd_addr(cmd_addr),
		.res_addr(res_addr), .pump_on(pump_on), .buf_connect(buf_connect),
		.direct_connect(direct_connect), .mux_sel(mux_sel), .conv_done(conv_done));
	alos_engine_model alos_engine_model_i (.clk(clk), .rst_b(rst_b), .go(go),
		.pump_on(pump_on), .conv_done(conv_done), .conv_start(conv_start),
		.cmd_advance(cmd_advance), .res_advance(res_advance));
	// Phase length counters and channel connection watch
	always @(posedge clk)
	begin
		cyc++;
		n_pump += pump_on;
		n_buf += buf_connect;
		n_dir += direct_connect;
		n_done += conv_done;
		if ((buf_connect | direct_connect) && mux_sel !== 16'h0200)
			bad++;
		if (!(buf_connect | direct_connect) && mux_sel !== 16'h0000)
			bad++;
		if (cyc == 5000)
		begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic report_and_stop();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		chk({pump_on, buf_connect, direct_connect, conv_done, mux_sel}, 32'h0);
		rst_b <= 1'b1;
		rd(`ALOS_OFF_SET1, rv);
		chk(rv, 32'h0);
		rd(`ALOS_OFF_CONV, rv);
		chk(rv, 32'h4);
		$display("reset test done");
		for (int i = 0; i < 8; i++)
		begin
			wr(ra[i], rw[i]);
			rd(ra[i], rv);
			chk(rv, rx[i]);
		end
		$display("register table done");
		wr(`ALOS_OFF_RES_BASE, 32'h80);
		wr(`ALOS_OFF_SET1, 32'h5);
		wr(`ALOS_OFF_CTRL, 32'h5);
		repeat (3) @(posedge clk);
		chk(cmd_addr, 32'h114);
		chk(res_addr, 32'h8A);
		cmd_idx_load <= 6'h03;
		cmd_idx_wr <= 1'b1;
		@(posedge clk);
		cmd_idx_wr <= 1'b0;
		wr(`ALOS_OFF_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk(cmd_addr, 32'h10C);
		chk(res_addr, 32'h80);
		wr(`ALOS_OFF_SET1, 32'h22);
		rd(`ALOS_OFF_SET1, rv);
		chk(rv, 32'h5);
		wr(`ALOS_OFF_CMD_BASE, 32'h200);
		rd(`ALOS_OFF_CMD_BASE, rv);
		chk(rv, 32'h100);
		wr(`ALOS_OFF_CTRL, 32'h7);
		wr(`ALOS_OFF_SET1, 32'h22);
		rd(`ALOS_OFF_SET1, rv);
		chk(rv, 32'h22);
		$display("address and lock test done");
		n_pump = 0;
		n_buf = 0;
		n_dir = 0;
		n_done = 0;
		bad = 0;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (int i = 0; i < 200 && conv_done !== 1'b1; i++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		chk(n_pump, 32'd4);
		chk(n_buf, 32'd4);
		chk(n_dir, 32'd6);
		chk(bad, 32'd0);
		chk(n_done, 32'd1);
		chk(cmd_addr, 32'h198);
		chk(res_addr, 32'hC6);
		$display("conversion test done");
		report_and_stop();
	end
endmodule
